// *** design/fapd_pkg.sv ***
// Purpose: constants shared by the floppy auto powerdown control block
// Assumes: 40 MHz core clock, 3-bit register offset
// Notes:   offsets are byte offsets from the floppy block base
package fapd_pkg;
   // -------------------------------------------------------------
   // register offsets
   // -------------------------------------------------------------
   localparam logic [2:0] OFS_STATUS_A     = 3'h0;
   localparam logic [2:0] OFS_STATUS_B     = 3'h1;
   localparam logic [2:0] OFS_DRIVE_OUTPUT = 3'h2;
   localparam logic [2:0] OFS_RATE_MAIN    = 3'h4; // write rate, read main
   localparam logic [2:0] OFS_COMMAND_DATA = 3'h5;
   localparam logic [2:0] OFS_DIGIN_CONFIG = 3'h7; // read digin, write cfg
   // -------------------------------------------------------------
   // field positions and values
   // -------------------------------------------------------------
   localparam int         DOC_MOTOR_HI  = 7;   // motor enables 7:4
   localparam int         DOC_MOTOR_LO  = 4;
   localparam int         DOC_RESET_N   = 2;   // low holds core in reset
   localparam int         RATE_SW_RESET = 7;
   localparam int         RATE_PWRDOWN  = 6;
   localparam logic [7:0] MAIN_IDLE     = 8'h80;
   localparam logic [7:0] DOC_RESET_VAL = 8'h00;
   localparam logic [7:0] RATE_RESET_VAL = 8'h02;
   localparam logic [7:0] CFG_RESET_VAL = 8'h00;
   localparam logic [13:0] BUS_IDLE     = 14'h3800; // strobes high
   // -------------------------------------------------------------
   // timing
   // -------------------------------------------------------------
   localparam int PD_TIME_MS  = 10;
   localparam int CLK_KHZ     = 40000;
   localparam int PD_CYCLES   = PD_TIME_MS * CLK_KHZ;
   localparam int TIMER_W     = 20;
   typedef enum logic {FAPD_ACTIVE, FAPD_AUTO_DOWN} fapd_state_t;
endpackage

// *** design/fapd_timer.sv ***
// Purpose: one-shot powerdown delay timer
// Assumes: restart wins over cancel
// Notes:   expired stays high until the next restart or cancel
`timescale 1ns/100ps
module fapd_timer #(
   parameter int CYCLES = 400000
) (
   // clock and reset
   input  wire logic core_clk,
   input  wire logic rst_n,
   // control
   input  wire logic restart,
   input  wire logic cancel,
   // status
   output logic      expired
);
   import fapd_pkg::*;

   logic [TIMER_W-1:0] count_reg;
   logic               armed_reg;

   // down counter, loaded on restart, disarmed on cancel
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         count_reg <= '0;
         armed_reg <= 1'b0;
      end else if (restart) begin
         count_reg <= TIMER_W'(CYCLES - 1);
         armed_reg <= 1'b1;
      end else if (cancel) begin
         count_reg <= '0;
         armed_reg <= 1'b0;
      end else if (count_reg != '0) begin
         count_reg <= count_reg - 1'b1;
      end
   end

   // expiry flag
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         expired <= 1'b0;
      end else begin
         expired <= armed_reg && count_reg == '0 && !restart && !cancel;
      end
   end
endmodule

// *** design/fapd_ctrl.sv ***
// Purpose: floppy controller auto powerdown control and host registers
// Assumes: host strobes arrive asynchronously; core status is on core_clk
// Notes:   powerdown gates drive outputs, host request outputs and no-wait-state only
`timescale 1ns/100ps
// Summary of operation
// - auto powerdown allowed only while the auto power enable is set
// - all motor enable bits must be zero to enter powerdown
// - main status must read 80h and controller interrupt be low
// - head unload timer must have expired before powerdown
// - a 10 ms timer starts on enable; powerdown only after expiry
// - clearing the enable cancels the timer and blocks auto powerdown
// - rate register powerdown bit overrides auto; clearing restores auto
// - hardware or software reset wakes the controller and resets it
// - writing a motor enable one wakes; reading drive output does not
// - host read of main status wakes the controller
// - host read or write of the data register wakes the controller
// - access wake clears only the rate powerdown bit; all other host-written register bits are untouched
// - every wake restarts the 10 ms timer before next powerdown
// - non-waking register reads return live status in powerdown
// - non-waking register writes are stored and used after wake
// - drive output or rate writes without motor or reset do not wake
// - after a non-waking access the block stays in low power
// - drive-facing outputs are disabled or tristated in powerdown
// - bus stays live; irq and drq low, no-wait-state released
// - drive power-off output follows shutdown, else auto state when enabled, else rate bit
module fapd_ctrl #(
   parameter int PD_DELAY = fapd_pkg::PD_CYCLES
) (
   // clock and reset
   input  wire logic       core_clk,
   input  wire logic       rst_n,
   // host i/o pins
   input  wire logic       io_cs_n,
   input  wire logic       io_rd_n,
   input  wire logic       io_wr_n,
   input  wire logic [2:0] io_addr,
   input  wire logic [7:0] io_data_in,
   output logic [7:0]      io_data_out,
   output logic            io_data_oe,
   output logic            no_wait_state_out_n,
   output logic            no_wait_state_oe,
   output logic            irq_out,
   output logic            drq_out,
   // configuration levels
   input  wire logic       auto_power_cfg_en,
   input  wire logic       shutdown_en,
   // controller core status
   input  wire logic [7:0] core_status_a,
   input  wire logic [7:0] core_status_b,
   input  wire logic [7:0] core_main_status,
   input  wire logic [7:0] core_read_data,
   input  wire logic [7:0] core_digital_input,
   input  wire logic       core_int,
   input  wire logic       core_drq,
   input  wire logic       head_unload_expired,
   // controller core control
   output logic [7:0]      drive_output_control,
   output logic [7:0]      rate_select,
   output logic [7:0]      config_control,
   output logic            core_reset,
   output logic            data_wr_pulse,
   output logic            data_rd_pulse,
   output logic [7:0]      data_wr_value,
   output logic            powered_down,
   // drive pins
   input  wire logic [1:0] core_motor_n,
   input  wire logic [1:0] core_select_n,
   input  wire logic       core_wgate,
   input  wire logic       core_wdata,
   output logic [1:0]      drv_motor_n,
   output logic [1:0]      drv_select_n,
   output logic            drv_wgate,
   output logic            drv_wdata,
   output logic            drv_oe,
   output logic            drive_power_off_out
);
   import fapd_pkg::*;

   // -------------------------------------------------------------
   // host pin synchroniser
   // -------------------------------------------------------------
   logic [13:0] bus_s1_reg;
   logic [13:0] bus_s2_reg;
   logic [13:0] bus_s3_reg;

   // two flops, then one more stage for edge detection
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         bus_s1_reg <= BUS_IDLE;
         bus_s2_reg <= BUS_IDLE;
         bus_s3_reg <= BUS_IDLE;
      end else begin
         bus_s1_reg <= {io_cs_n, io_rd_n, io_wr_n, io_addr, io_data_in};
         bus_s2_reg <= bus_s1_reg;
         bus_s3_reg <= bus_s2_reg;
      end
   end

   logic       rd_now;
   logic       rd_prev;
   logic       wr_prev;
   logic       wr_now;
   logic       rd_start;
   logic       wr_done;
   logic [2:0] rd_addr;
   logic [2:0] wr_addr;
   logic [7:0] wr_data;

   // read acts on strobe start, write on strobe end with held data
   assign rd_now   = !bus_s2_reg[13] && !bus_s2_reg[12];
   assign rd_prev  = !bus_s3_reg[13] && !bus_s3_reg[12];
   assign wr_now   = !bus_s2_reg[13] && !bus_s2_reg[11];
   assign wr_prev  = !bus_s3_reg[13] && !bus_s3_reg[11];
   assign rd_start = rd_now && !rd_prev;
   assign wr_done  = wr_prev && !wr_now;
   assign rd_addr  = bus_s2_reg[10:8];
   assign wr_addr  = bus_s3_reg[10:8];
   assign wr_data  = bus_s3_reg[7:0];

   // -------------------------------------------------------------
   // access decode and wake events
   // -------------------------------------------------------------
   logic doc_wr;
   logic rate_wr;
   logic cfg_wr;
   logic data_wr;
   logic main_rd;
   logic data_rd;
   logic motor_wake;
   logic sw_reset_wake;
   logic wake;

   assign doc_wr  = wr_done && wr_addr == OFS_DRIVE_OUTPUT;
   assign rate_wr = wr_done && wr_addr == OFS_RATE_MAIN;
   assign cfg_wr  = wr_done && wr_addr == OFS_DIGIN_CONFIG;
   assign data_wr = wr_done && wr_addr == OFS_COMMAND_DATA;
   assign main_rd = rd_start && rd_addr == OFS_RATE_MAIN;
   assign data_rd = rd_start && rd_addr == OFS_COMMAND_DATA;
   // motor wake only on a write carrying a one; drive output reads never wake
   assign motor_wake = doc_wr
      && wr_data[DOC_MOTOR_HI:DOC_MOTOR_LO] != 4'h0;
   // software reset through either control register
   assign sw_reset_wake = (doc_wr && !wr_data[DOC_RESET_N])
      || (rate_wr && wr_data[RATE_SW_RESET]);
   // other writes to these registers leave the state alone
   assign wake = motor_wake || sw_reset_wake || main_rd
      || data_rd || data_wr;

   // -------------------------------------------------------------
   // host-written registers
   // -------------------------------------------------------------
   logic [7:0] doc_reg;
   logic [7:0] rate_reg;
   logic [7:0] cfg_reg;

   // stored at any time, powerdown or not; the core sees them a cycle later
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         doc_reg <= DOC_RESET_VAL;
      end else if (doc_wr) begin
         doc_reg <= wr_data;
      end
   end

   // rate select; reset bit is a pulse and does not stay set
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         rate_reg <= RATE_RESET_VAL;
      end else if (rate_wr) begin
         rate_reg <= {1'b0, wr_data[6:0]};
      end else if (wake) begin
         rate_reg[RATE_PWRDOWN] <= 1'b0;
      end
   end

   // configuration control
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         cfg_reg <= CFG_RESET_VAL;
      end else if (cfg_wr) begin
         cfg_reg <= wr_data;
      end
   end

   // -------------------------------------------------------------
   // powerdown timer and state
   // -------------------------------------------------------------
   logic        en_prev_reg;
   logic        rate_pd;
   logic        rate_pd_prev_reg;
   logic        timer_restart;
   logic        timer_expired;
   logic        idle_all;
   fapd_state_t state_reg;
   fapd_state_t state_next;

   assign rate_pd = rate_reg[RATE_PWRDOWN];

   // edge history for enable and rate powerdown bit
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         en_prev_reg      <= 1'b0;
         rate_pd_prev_reg <= 1'b0;
      end else begin
         en_prev_reg      <= auto_power_cfg_en;
         rate_pd_prev_reg <= rate_pd;
      end
   end

   // restart on enable, on each wake, and on leaving rate powerdown
   assign timer_restart = (auto_power_cfg_en && !en_prev_reg)
      || wake
      || (rate_pd_prev_reg && !rate_pd);

   fapd_timer #(
      .CYCLES (PD_DELAY)
   ) u_timer (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .restart  (timer_restart),
      .cancel   (!auto_power_cfg_en),
      .expired  (timer_expired)
   );

   // idle entry conditions together; rate powerdown bit and wake are checked in the next-state logic
   assign idle_all = auto_power_cfg_en
      && doc_reg[DOC_MOTOR_HI:DOC_MOTOR_LO] == 4'h0
      && core_main_status == MAIN_IDLE && !core_int
      && head_unload_expired
      && timer_expired;

   // next state; wake only moves the state, never clears core state
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         FAPD_ACTIVE: begin
            if (idle_all && !rate_pd && !wake) begin
               state_next = FAPD_AUTO_DOWN;
            end
         end
         FAPD_AUTO_DOWN: begin
            if (wake || !auto_power_cfg_en) begin
               state_next = FAPD_ACTIVE;
            end
         end
      endcase
   end

   // state register; a non-waking access leaves it in powerdown
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         state_reg <= FAPD_ACTIVE;
      end else begin
         state_reg <= state_next;
      end
   end

   logic pd_now;
   assign pd_now = state_reg == FAPD_AUTO_DOWN || rate_pd;

   // -------------------------------------------------------------
   // host read path
   // -------------------------------------------------------------
   logic [7:0] rd_mux;
   logic       rd_mapped;

   // live status, so reads in powerdown are true
   always_comb begin
      rd_mux    = 8'h00;
      rd_mapped = 1'b1;
      unique case (rd_addr)
         OFS_STATUS_A:     rd_mux = core_status_a;
         OFS_STATUS_B:     rd_mux = core_status_b;
         OFS_DRIVE_OUTPUT: rd_mux = doc_reg;
         OFS_RATE_MAIN:    rd_mux = core_main_status;
         OFS_COMMAND_DATA: rd_mux = core_read_data;
         OFS_DIGIN_CONFIG: rd_mux = core_digital_input;
         default:          rd_mapped = 1'b0;
      endcase
   end

   // bus pins stay live in powerdown
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         io_data_out <= 8'h00;
         io_data_oe  <= 1'b0;
      end else begin
         io_data_out <= rd_mux;
         io_data_oe  <= rd_now && rd_mapped;
      end
   end

   // no-wait-state: pulled low on any access, mapped or not, released in powerdown
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         no_wait_state_out_n <= 1'b1;
         no_wait_state_oe    <= 1'b0;
      end else begin
         no_wait_state_out_n <= 1'b0;
         no_wait_state_oe    <= (rd_now || wr_now) && !pd_now;
      end
   end

   // -------------------------------------------------------------
   // core-facing outputs
   // -------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         drive_output_control <= DOC_RESET_VAL;
         rate_select          <= RATE_RESET_VAL;
         config_control       <= CFG_RESET_VAL;
         core_reset           <= 1'b1;
         data_wr_pulse        <= 1'b0;
         data_rd_pulse        <= 1'b0;
         data_wr_value        <= 8'h00;
         powered_down         <= 1'b0;
      end else begin
         drive_output_control <= doc_reg;
         rate_select          <= rate_reg;
         config_control       <= cfg_reg;
         core_reset           <= !doc_reg[DOC_RESET_N]
            || (rate_wr && wr_data[RATE_SW_RESET]);
         data_wr_pulse        <= data_wr;
         data_rd_pulse        <= data_rd;
         data_wr_value        <= data_wr ? wr_data : data_wr_value;
         powered_down         <= pd_now;
      end
   end

   // requests held low while powered down
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         irq_out <= 1'b0;
         drq_out <= 1'b0;
      end else begin
         irq_out <= core_int && !pd_now;
         drq_out <= core_drq && !pd_now;
      end
   end

   // drive-facing pins: values follow core, enable drops in powerdown
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         drv_motor_n  <= 2'h3;
         drv_select_n <= 2'h3;
         drv_wgate    <= 1'b0;
         drv_wdata    <= 1'b1;
         drv_oe       <= 1'b0;
      end else begin
         drv_motor_n  <= core_motor_n;
         drv_select_n <= core_select_n;
         drv_wgate    <= core_wgate;
         drv_wdata    <= core_wdata;
         drv_oe       <= !pd_now;
      end
   end

   // drive power-off: shutdown, else auto state when enabled, else rate
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         drive_power_off_out <= 1'b0;
      end else begin
         drive_power_off_out <= shutdown_en
            || (auto_power_cfg_en ? state_reg == FAPD_AUTO_DOWN
                                  : rate_pd);
      end
   end

   // -------------------------------------------------------------
   // assertions
   // -------------------------------------------------------------
   a_entry_cause: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      (state_reg == FAPD_AUTO_DOWN && $past(state_reg) == FAPD_ACTIVE)
      |-> $past(core_main_status == MAIN_IDLE && !core_int
                && head_unload_expired && timer_expired))
      else $error("powerdown entered without idle conditions");

   a_motor_blocks: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      (state_reg == FAPD_ACTIVE
       && doc_reg[DOC_MOTOR_HI:DOC_MOTOR_LO] != 4'h0)
      |=> state_reg == FAPD_ACTIVE)
      else $error("powerdown with a motor enabled");

   a_enable_off: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      !auto_power_cfg_en |=> state_reg == FAPD_ACTIVE && !timer_expired)
      else $error("auto powerdown active while disabled");

   a_main_wake: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      (state_reg == FAPD_AUTO_DOWN && main_rd)
      |=> state_reg == FAPD_ACTIVE ##1 !timer_expired)
      else $error("main status read did not wake");

   a_quiet_write: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      (state_reg == FAPD_AUTO_DOWN && auto_power_cfg_en && doc_wr
       && wr_data[DOC_RESET_N] && wr_data[7:4] == 4'h0)
      |=> state_reg == FAPD_AUTO_DOWN)
      else $error("plain drive output write woke the block");

   a_req_low: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      pd_now |=> !irq_out && !drq_out && !no_wait_state_oe)
      else $error("request output active in powerdown");

   a_drive_off: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      $rose(pd_now) |=> !drv_oe ##1 (!drv_oe || !pd_now))
      else $error("drive pins still enabled in powerdown");

   a_power_pin: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      (shutdown_en || (!auto_power_cfg_en && rate_pd))
      |=> drive_power_off_out)
      else $error("drive power-off output not raised");

   a_rate_override: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      (rate_pd && state_reg == FAPD_ACTIVE)
      |=> state_reg == FAPD_ACTIVE && powered_down)
      else $error("rate powerdown not overriding auto state");
endmodule

// *** verif/fapd_host.sv ***
// Purpose: host processor model issuing byte i/o cycles
// Assumes: strobes held 6 clocks low, then 5 clocks high
// Notes:   read data is taken while the read strobe is still low
`timescale 1ns/100ps
module fapd_host (
   // clock
   input  wire logic       core_clk,
   // host bus
   output logic            io_cs_n,
   output logic            io_rd_n,
   output logic            io_wr_n,
   output logic [2:0]      io_addr,
   output logic [7:0]      io_data_in,
   input  wire logic [7:0] io_data_out
);
   // idle bus at time zero
   initial begin
      io_cs_n = 1'b1;
      io_rd_n = 1'b1;
      io_wr_n = 1'b1;
      io_addr = 3'h3;
      io_data_in = 8'h00;
   end
   // write cycle; data held past the strobe, then no longer shown
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge core_clk);
      io_addr <= a;
      io_data_in <= d;
      io_cs_n <= 1'b0;
      io_wr_n <= 1'b0;
      repeat (6) @(posedge core_clk);
      io_cs_n <= 1'b1;
      io_wr_n <= 1'b1;
      // one edge more than the wake path needs, so that state
      // launched by the write has settled when the task returns
      repeat (5) @(posedge core_clk);
      io_data_in <= ~d;
   endtask
   // read cycle; answer taken at the last edge of the low strobe
   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge core_clk);
      io_addr <= a;
      io_cs_n <= 1'b0;
      io_rd_n <= 1'b0;
      repeat (6) @(posedge core_clk);
      d = io_data_out;
      io_cs_n <= 1'b1;
      io_rd_n <= 1'b1;
      repeat (5) @(posedge core_clk);
   endtask
endmodule

// *** verif/fdc_auto_powerdown_ctrl_bench.sv ***
// Purpose: self-checking bench for the auto powerdown control
// Assumes: powerdown delay shortened to 20 clocks
// Notes:   host cycles come from the host model instance
`timescale 1ns/100ps
module fdc_auto_powerdown_ctrl_bench;
   import fapd_pkg::*;
   localparam int DLY = 20;
   logic       core_clk = 1'b0, rst_n = 1'b0;
   logic       io_cs_n, io_rd_n, io_wr_n, io_data_oe, irq_out, drq_out;
   logic       no_wait_state_out_n, no_wait_state_oe, core_reset;
   logic       data_wr_pulse, data_rd_pulse, powered_down, drv_oe;
   logic       drv_wgate, drv_wdata, drive_power_off_out;
   logic [2:0] io_addr;
   logic [7:0] io_data_in, io_data_out, drive_output_control;
   logic [7:0] rate_select, config_control, data_wr_value, rd;
   logic [1:0] drv_motor_n, drv_select_n;
   logic       auto_power_cfg_en = 1'b0, shutdown_en = 1'b0;
   logic [7:0] core_status_a = 8'h5A, core_status_b = 8'hC3;
   logic [7:0] core_main_status = MAIN_IDLE, core_read_data = 8'h3C;
   logic [7:0] core_digital_input = 8'h81;
   logic       core_int = 1'b0, core_drq = 1'b0;
   logic       head_unload_expired = 1'b1;
   logic [1:0] core_motor_n = 2'h2, core_select_n = 2'h1;
   logic       core_wgate = 1'b1, core_wdata = 1'b0;
   int         n_errors = 0, compares = 0, cycles = 0, n;
   int         n_wr = 0, n_rd = 0;
   // 40 MHz clock
   always #12.5 core_clk = ~core_clk;
   fapd_ctrl #(.PD_DELAY(DLY)) dut (.core_clk, .rst_n, .io_cs_n,
      .io_rd_n, .io_wr_n, .io_addr, .io_data_in, .io_data_out,
      .io_data_oe, .no_wait_state_out_n, .no_wait_state_oe, .irq_out,
      .drq_out, .auto_power_cfg_en, .shutdown_en, .core_status_a,
      .core_status_b, .core_main_status, .core_read_data,
      .core_digital_input, .core_int, .core_drq, .head_unload_expired,
      .drive_output_control, .rate_select, .config_control, .core_reset,
      .data_wr_pulse, .data_rd_pulse, .data_wr_value, .powered_down,
      .core_motor_n, .core_select_n, .core_wgate, .core_wdata,
      .drv_motor_n, .drv_select_n, .drv_wgate, .drv_wdata, .drv_oe,
      .drive_power_off_out);
   fapd_host host (.core_clk, .io_cs_n, .io_rd_n, .io_wr_n, .io_addr,
      .io_data_in, .io_data_out);
   // compare one value and count it
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen,
                  exp);
      end
   endtask
   // counts and verdict
   task automatic test_done();
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // wait, bounded, for the block to power down
   task automatic wait_down();
      n = 0;
      while (powered_down !== 1'b1 && n < 100) begin
         @(posedge core_clk);
         n++;
      end
      check(8'(powered_down), 8'h01);
   endtask
   // data register pulses handed to the core
   always @(posedge core_clk) begin
      if (data_wr_pulse === 1'b1)
         n_wr++;
      if (data_rd_pulse === 1'b1)
         n_rd++;
   end
   // hang guard
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         test_done();
      end
   end
   // -------------------------------------------------------------
   // main sequence
   // -------------------------------------------------------------
   initial begin
      repeat (3) @(posedge core_clk);
      rst_n <= 1'b1;
      @(posedge core_clk);
      #1 check(drive_output_control, DOC_RESET_VAL);
      check(rate_select, RATE_RESET_VAL);
      check(config_control, CFG_RESET_VAL);
      check(8'(core_reset), 8'h01);
      host.wr(OFS_DRIVE_OUTPUT, 8'h04);
      repeat (40) @(posedge core_clk);
      check(8'(powered_down), 8'h00);
      auto_power_cfg_en <= 1'b1;
      wait_down();
      check(8'(n >= DLY), 8'h01);
      core_drq <= 1'b1;
      repeat (3) @(posedge core_clk);
      check(8'(drv_oe), 8'h00);
      check(8'(drq_out), 8'h00);
      check(8'(drive_power_off_out), 8'h01);
      core_drq <= 1'b0;
      // non-waking accesses: live reads, stored writes
      host.rd(OFS_STATUS_A, rd);
      check(rd, 8'h5A);
      host.rd(OFS_STATUS_B, rd);
      check(rd, 8'hC3);
      host.rd(OFS_DIGIN_CONFIG, rd);
      check(rd, 8'h81);
      host.wr(OFS_DIGIN_CONFIG, 8'h03);
      host.wr(OFS_RATE_MAIN, 8'h01);
      host.wr(OFS_DRIVE_OUTPUT, 8'h0C);
      host.rd(OFS_DRIVE_OUTPUT, rd);
      check(rd, 8'h0C);
      check(config_control, 8'h03);
      check(rate_select, 8'h01);
      check(8'(powered_down), 8'h01);
      // waking accesses: main read, data read, data write
      for (int k = 0; k < 3; k++) begin
         if (k == 0)
            host.rd(OFS_RATE_MAIN, rd);
         else if (k == 1)
            host.rd(OFS_COMMAND_DATA, rd);
         else
            host.wr(OFS_COMMAND_DATA, 8'hA5);
         check(8'(powered_down), 8'h00);
         wait_down();
      end
      check(data_wr_value, 8'hA5);
      check(config_control, 8'h03);
      check(drive_output_control, 8'h0C);
      // motor write wakes and holds the block up
      host.wr(OFS_DRIVE_OUTPUT, 8'h1C);
      repeat (40) @(posedge core_clk);
      check(8'(powered_down), 8'h00);
      check(8'(drv_oe), 8'h01);
      check({2'h0, drv_motor_n, drv_select_n, drv_wgate, drv_wdata},
            8'h26);
      host.wr(OFS_DRIVE_OUTPUT, 8'h0C);
      wait_down();
      // interrupt, main status, head unload each missing in turn blocks entry
      for (int k = 0; k < 3; k++) begin
         core_int <= (k == 0);
         core_main_status <= (k == 1) ? 8'h90 : MAIN_IDLE;
         head_unload_expired <= (k != 2);
         host.rd(OFS_RATE_MAIN, rd);
         repeat (40) @(posedge core_clk);
         check(8'(powered_down), 8'h00);
         check(8'(irq_out), 8'(k == 0));
      end
      core_int <= 1'b0;
      head_unload_expired <= 1'b1;
      wait_down();
      // enable cleared, then rate powerdown bit, then auto again
      auto_power_cfg_en <= 1'b0;
      repeat (40) @(posedge core_clk);
      check(8'(powered_down), 8'h00);
      check(8'(drive_power_off_out), 8'h00);
      host.wr(OFS_RATE_MAIN, 8'h41);
      repeat (3) @(posedge core_clk);
      check(8'(powered_down), 8'h01);
      check(8'(drive_power_off_out), 8'h01);
      host.wr(OFS_COMMAND_DATA, 8'h11);
      shutdown_en <= 1'b1;
      repeat (3) @(posedge core_clk);
      check(8'(powered_down), 8'h00);
      check(8'(drive_power_off_out), 8'h01);
      shutdown_en <= 1'b0;
      auto_power_cfg_en <= 1'b1;
      wait_down();
      // software reset through drive output, then the rate register
      host.wr(OFS_DRIVE_OUTPUT, 8'h08);
      check(8'(powered_down), 8'h00);
      check(8'(core_reset), 8'h01);
      host.wr(OFS_DRIVE_OUTPUT, 8'h0C);
      wait_down();
      host.wr(OFS_RATE_MAIN, 8'h81);
      check(8'(powered_down), 8'h00);
      wait_down();
      rst_n <= 1'b0;
      repeat (3) @(posedge core_clk);
      rst_n <= 1'b1;
      #1 check(8'(powered_down), 8'h00);
      check(drive_output_control, DOC_RESET_VAL);
      check(8'(n_wr), 8'h02);
      check(8'(n_rd), 8'h01);
      test_done();
   end
endmodule
